// *** programmable_wakeup_timer_tb.sv ***
// Purpose: Self-checking bench of the wake-up timer.
// Assumes: The crystal input toggles every system clock cycle.
// Notes:   Compare is set small so that one second lasts a few thousand
//          cycles.
`timescale 1ns/1ps
module programmable_wakeup_timer_tb;
  logic                  i_clk;
  logic                  i_rst;
  logic                  i_xtal;
  wkt_pkg::wkt_bus_req_t i_bus;
  logic [31:0]           o_rdata;
  logic                  i_rx_valid;
  logic [7:0]            i_rx_data;
  logic                  o_tx_valid;
  wkt_pkg::wkt_msg_t     o_tx;
  logic                  o_wake;
  logic                  o_irq;
  logic                  send;
  logic [7:0]            secs;
  logic                  asleep;
  logic [15:0]           cmp;
  logic [15:0]           plen;
  int                    miscompares;
  int                    comparisons;
  int                    cyc;
  int                    last_cyc;
  int                    seed;
  int                    bad;

  wkt_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_xtal(i_xtal),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data), .o_tx_valid(o_tx_valid), .o_tx(o_tx),
    .o_wake(o_wake), .o_irq(o_irq));
  wkt_host_model host (.i_clk(i_clk), .i_send(send), .i_secs(secs),
    .i_wake(o_wake), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
    .o_asleep(asleep));

  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc    <= cyc + 1;
    i_xtal <= ~i_xtal;
  end
  always @(posedge i_clk) begin
    if (cyc == 95000) begin
      miscompares++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{wr: w, rd: !w, addr: a, wdata: wd};
    @(posedge i_clk);
    i_bus <= '0;
    #1;
    d = o_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(nm, e, d & m);
  endtask
  function automatic wkt_pkg::wkt_msg_t exp_msg(input logic [7:0] r);
    wkt_pkg::wkt_msg_t m;
    m.is_wake = (r == 8'h01);
    m.secs    = (r == 8'h01) ? 8'h00 : r - 8'h01;
    return m;
  endfunction
  function automatic int period(input logic [15:0] c);
    return 2 * (int'(wkt_pkg::PRESC_MAX) + 1) * (int'(c) + 1);
  endfunction
  task automatic start(input logic [7:0] n);
    logic [8:0] exp_rem;
    exp_rem = {n != 8'h00, n};
    @(posedge i_clk);
    send <= 1'b1;
    secs <= n;
    @(posedge i_clk);
    send <= 1'b0;
    rd_chk("remain", wkt_pkg::ADDR_REMAIN, 32'h1ff, 32'(exp_rem));
    rd_chk("load", wkt_pkg::ADDR_STATUS, 32'h4, 32'h4);
  endtask
  task automatic run_count(input logic [7:0] n, input logic en);
    int wl;
    for (int r = n; r >= 1; r--) begin
      do @(negedge i_clk); while (o_tx_valid !== 1'b1);
      chk("message", 32'(exp_msg(8'(r))), 32'(o_tx));
      if (r < n) chk("tick gap", period(cmp), cyc - last_cyc);
      last_cyc = cyc;
      if (r > 1) rd_chk("remain", 8'h04, 32'h1ff, {23'h1, 8'(r - 1)});
    end
    chk("irq", 32'(en), 32'(o_irq));
    wl = 0;
    while (o_wake === 1'b1) begin
      wl++;
      @(negedge i_clk);
    end
    chk("wake length", 32'(plen), wl);
    chk("host awake", 32'h0, 32'(asleep));
    wr(wkt_pkg::ADDR_CLEAR, 32'h7);
    rd_chk("status", wkt_pkg::ADDR_STATUS, 32'h2, 32'h0);
    chk("irq cleared", 32'h0, 32'(o_irq));
    $display("test countdown of %0d done", n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_xtal = 1'b0;
    i_bus = '0;
    send = 1'b0;
    secs = 8'h00;
    miscompares = 0;
    comparisons = 0;
    cyc = 0;
    last_cyc = 0;
    seed = 32'he3140c18;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk("compare", wkt_pkg::ADDR_CMP, '1, 32'h1f);
    rd_chk("plen", wkt_pkg::ADDR_PLEN, '1, 32'hfa);
    rd_chk("status", wkt_pkg::ADDR_STATUS, '1, 32'h0);
    rd_chk("enable", wkt_pkg::ADDR_ENABLE, '1, 32'h0);
    rd_chk("clear", wkt_pkg::ADDR_CLEAR, '1, 32'h0);
    rd_chk("unmapped", 8'h18, '1, 32'h0);
    wr(wkt_pkg::ADDR_CMP, 32'h5a5affff);
    rd_chk("compare", wkt_pkg::ADDR_CMP, '1, 32'hffff);
    cmp = 16'h0000;
    plen = 16'h0007;
    wr(wkt_pkg::ADDR_CMP, 32'(cmp));
    wr(wkt_pkg::ADDR_PLEN, 32'(plen));
    wr(wkt_pkg::ADDR_ENABLE, 32'h2);
    $display("test registers done");
    start(8'h03);
    run_count(8'h03, 1'b1);
    start(8'h05);
    do @(negedge i_clk); while (o_tx_valid !== 1'b1);
    chk("message", 32'(exp_msg(8'h05)), 32'(o_tx));
    // The clear lands on the very edge at which the next tick is sampled.
    repeat (period(cmp) - 2) @(posedge i_clk);
    wr(wkt_pkg::ADDR_CLEAR, 32'h1);
    rd_chk("set beats clear", wkt_pkg::ADDR_STATUS, 32'h1, 32'h1);
    start(8'h02);
    run_count(8'h02, 1'b1);
    start(8'hff);
    start(8'h00);
    bad = 0;
    repeat (2 * period(cmp)) begin
      @(negedge i_clk);
      if (o_tx_valid !== 1'b0 || o_wake !== 1'b0) bad++;
    end
    chk("stopped", 32'h0, bad);
    rd_chk("active", wkt_pkg::ADDR_REMAIN, 32'h100, 32'h0);
    $display("test stop done");
    for (int i = 0; i < 3; i++) begin
      cmp = 16'($unsigned($random(seed)) % 2);
      plen = 16'($unsigned($random(seed)) % 16 + 1);
      secs = 8'($unsigned($random(seed)) % 3 + 1);
      wr(wkt_pkg::ADDR_CMP, 32'(cmp));
      wr(wkt_pkg::ADDR_PLEN, 32'(plen));
      wr(wkt_pkg::ADDR_ENABLE, (i == 1) ? 32'h0 : 32'h2);
      start(secs);
      run_count(secs, i != 1);
    end
    wrap_up();
  end
endmodule

// *** wkt_host_model.sv ***
// Purpose: Host side of the byte link that sends wake times and sleeps.
// Assumes: Link bytes are already deframed into one-cycle strobes.
// Notes:   When idle, the data line inverts every cycle, alternating the last byte and its inverse.
`timescale 1ns/1ps
module wkt_host_model (
  // Clock
  input  wire logic              i_clk,
  // Bench control
  input  wire logic              i_send,
  input  wire logic [7:0]        i_secs,
  // Device side
  input  wire logic              i_wake,
  output logic                   o_rx_valid,
  output logic [7:0]             o_rx_data,
  output logic                   o_asleep
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_asleep   = 1'b0;
  end
  always @(posedge i_clk) begin
    o_rx_valid <= i_send;
    o_rx_data  <= i_send ? i_secs : ~o_rx_data;
  end
  always @(posedge i_clk) begin
    if (i_send) begin
      o_asleep <= 1'b1;
    end else if (i_wake) begin
      o_asleep <= 1'b0;
    end
  end
endmodule

// *** wkt_pkg.sv ***
// Purpose: Shared constants and types of the programmable wake-up timer.
// Assumes: A 250 MHz system clock and a 32.768 kHz crystal level input.
// Notes:   Register offsets are byte addresses on a 32-bit register port.
package wkt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timebase.
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned XTAL_HZ        = 32768;
  localparam logic [9:0]  PRESC_MAX      = 10'h3ff;
  localparam int unsigned TICKS_PER_SEC  = 32;
  localparam logic [15:0] CMP_RESET      = 16'(TICKS_PER_SEC - 1);
  localparam int unsigned WAKE_PULSE_NS  = 1000;
  localparam int unsigned WAKE_PULSE_CYC = (WAKE_PULSE_NS * CLK_MHZ) / 1000;
  localparam logic [15:0] PLEN_RESET     = 16'(WAKE_PULSE_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [7:0]  ADDR_CMP    = 8'h00;
  localparam logic [7:0]  ADDR_REMAIN = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_CLEAR  = 8'h0c;
  localparam logic [7:0]  ADDR_ENABLE = 8'h10;
  localparam logic [7:0]  ADDR_PLEN   = 8'h14;

  // Event bits shared by status, clear and enable, and the remain active bit.
  localparam int unsigned STS_W    = 3;
  localparam int unsigned STS_TICK = 0;
  localparam int unsigned STS_WAKE = 1;
  localparam int unsigned STS_LOAD = 2;
  localparam int unsigned REM_ACT  = 8;
  localparam logic [STS_W-1:0] STS_RESET = 3'h0;
  localparam logic [STS_W-1:0] EN_RESET  = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } wkt_bus_req_t;

  typedef struct packed {
    logic       is_wake;
    logic [7:0] secs;
  } wkt_msg_t;

  typedef enum logic [0:0] {
    WKT_IDLE,
    WKT_COUNT
  } wkt_state_t;

endpackage

// *** wkt_prescale.sv ***
// Purpose: Crystal edge detect, divide by 1024 and one-second tick counter.
// Assumes: The crystal level input is synchronous to the system clock.
// Notes:   A restart clears the divider phase so a reload counts whole seconds.
`timescale 1ns/1ps
module wkt_prescale (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Crystal level and control
  input  wire logic        i_xtal,
  input  wire logic        i_restart,
  input  wire logic [15:0] i_cmp,
  // Tick out
  output logic             o_tick
);

  logic        xtal_r;
  logic [9:0]  presc_r;
  logic [9:0]  presc_nxt;
  logic [15:0] ctr_r;
  logic [15:0] ctr_nxt;
  logic        tick_nxt;
  logic        xedge;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    xedge     = i_xtal & ~xtal_r;
    presc_nxt = presc_r;
    ctr_nxt   = ctr_r;
    tick_nxt  = 1'b0;
    if (i_restart) begin
      presc_nxt = 10'h000;
      ctr_nxt   = 16'h0000;
    end else if (xedge) begin
      presc_nxt = presc_r + 10'h001;
      if (presc_r == wkt_pkg::PRESC_MAX) begin
        if (ctr_r == i_cmp) begin
          tick_nxt = 1'b1;
          ctr_nxt  = 16'h0000;
        end else begin
          ctr_nxt = ctr_r + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      xtal_r  <= 1'b0;
      presc_r <= 10'h000;
      ctr_r   <= 16'h0000;
      o_tick  <= 1'b0;
    end else begin
      xtal_r  <= i_xtal;
      presc_r <= presc_nxt;
      ctr_r   <= ctr_nxt;
      o_tick  <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_tick_restart: assert property (
    o_tick |-> ctr_r == 16'h0000 && presc_r == 10'h000
      && $past(ctr_r) == $past(i_cmp))
    else $error("tick without compare match or counter restart");

  a_presc_hold: assert property (
    !xedge && !i_restart |=> presc_r == $past(presc_r))
    else $error("prescaler moved without a crystal edge");

  a_ctr_step: assert property (
    ctr_r != $past(ctr_r) && !$past(i_restart)
      |-> $past(presc_r) == wkt_pkg::PRESC_MAX && $past(xedge))
    else $error("tick counter moved off the divide-by-1024 carry");

endmodule

// *** wkt_pulse.sv ***
// Purpose: Stretches a wake start strobe into a wake pulse of set length.
// Assumes: A length of zero behaves as a length of one cycle.
// Notes:   A new start during a pulse restarts the length count.
`timescale 1ns/1ps
module wkt_pulse (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Control
  input  wire logic        i_start,
  input  wire logic [15:0] i_len,
  // Wake line
  output logic             o_wake
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        wake_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cnt_nxt  = cnt_r;
    if (i_start) begin
      cnt_nxt = (i_len == 16'h0000) ? 16'h0001 : i_len;
    end else if (cnt_r != 16'h0000) begin
      cnt_nxt = cnt_r - 16'h0001;
    end
    wake_nxt = (cnt_nxt != 16'h0000);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= 16'h0000;
      o_wake <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_wake <= wake_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_pulse_end: assert property (
    o_wake && cnt_r == 16'h0001 && !i_start |=> !o_wake)
    else $error("wake pulse did not end after its length");

  a_pulse_hold: assert property (
    i_start && i_len > 16'h0002 |=> o_wake [*3])
    else $error("wake pulse shorter than its length");

endmodule

// *** wkt_top.sv ***
// Purpose: Programmable wake-up timer with byte link and register port.
// Assumes: Link bytes arrive as one-cycle strobes, already deframed.
// Notes:   Countdown seconds come from the crystal, not the system clock.
//
// Overview of operation
// - Count only from the 32.768 kHz crystal as the timebase.
// - Divide crystal by 1024 ahead of the seconds tick counter.
// - Thirty-two prescaled counts make exactly one second.
// - Tick when counter matches compare value, then restart from zero.
// - Compare value and matched counter are both 16 bits wide.
// - Compare value starts at 31, giving one tick each second.
// - Wake time is an unsigned byte of seconds, 1 to 255.
// - Countdown starts at once when the time byte arrives.
// - At zero, raise wake line and send a wake message.
// - After full time, drive a low-to-high wake pulse.
// - Send remaining seconds over the link while counting.
// - A new byte at any time replaces the old countdown.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module wkt_top (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Crystal level
  input  wire logic                 i_xtal,
  // Register port
  input  wire wkt_pkg::wkt_bus_req_t i_bus,
  output logic [31:0]               o_rdata,
  // Received link bytes
  input  wire logic                 i_rx_valid,
  input  wire logic [7:0]           i_rx_data,
  // Transmitted link messages
  output logic                      o_tx_valid,
  output wkt_pkg::wkt_msg_t         o_tx,
  // Wake line and interrupt
  output logic                      o_wake,
  output logic                      o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic wkt_pkg::wkt_msg_t mk_msg(input logic w,
                                               input logic [7:0] s);
    wkt_pkg::wkt_msg_t m;
    m.is_wake = w;
    m.secs    = s;
    return m;
  endfunction

  function automatic logic hit(input wkt_pkg::wkt_bus_req_t b,
                               input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  wkt_pkg::wkt_state_t      state_r;
  wkt_pkg::wkt_state_t      state_nxt;
  logic [7:0]               remain_r;
  logic [7:0]               remain_nxt;
  logic                     tx_vld_nxt;
  wkt_pkg::wkt_msg_t        tx_nxt;
  logic                     wake_go;
  logic                     restart;
  logic                     tick;

  logic [15:0]              cmp_r;
  logic [15:0]              cmp_nxt;
  logic [15:0]              plen_r;
  logic [15:0]              plen_nxt;
  logic [wkt_pkg::STS_W-1:0] status_r;
  logic [wkt_pkg::STS_W-1:0] status_nxt;
  logic [wkt_pkg::STS_W-1:0] en_r;
  logic [wkt_pkg::STS_W-1:0] en_nxt;
  logic [wkt_pkg::STS_W-1:0] clr;
  logic [wkt_pkg::STS_W-1:0] evt;
  logic [31:0]              rdata_nxt;
  logic                     irq_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and wake pulse.

  wkt_prescale u_presc (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_xtal    (i_xtal),
    .i_restart (restart),
    .i_cmp     (cmp_r),
    .o_tick    (tick)
  );

  wkt_pulse u_pulse (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (wake_go),
    .i_len   (plen_r),
    .o_wake  (o_wake)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Countdown.
  // A byte and a tick in the same cycle: the byte wins, since it replaces
  // the whole countdown and restarts the second phase anyway.

  always_comb begin
    state_nxt  = state_r;
    remain_nxt = remain_r;
    tx_vld_nxt = 1'b0;
    tx_nxt     = o_tx;
    wake_go    = 1'b0;
    restart    = 1'b0;
    if (i_rx_valid) begin
      restart    = 1'b1;
      remain_nxt = i_rx_data;
      state_nxt  = (i_rx_data != 8'h00) ? wkt_pkg::WKT_COUNT
                                        : wkt_pkg::WKT_IDLE;
    end else begin
      unique case (state_r)
        wkt_pkg::WKT_IDLE: begin
          state_nxt = wkt_pkg::WKT_IDLE;
        end
        wkt_pkg::WKT_COUNT: begin
          if (tick) begin
            remain_nxt = remain_r - 8'h01;
            tx_vld_nxt = 1'b1;
            if (remain_r == 8'h01) begin
              state_nxt = wkt_pkg::WKT_IDLE;
              wake_go   = 1'b1;
              tx_nxt    = mk_msg(1'b1, 8'h00);
            end else begin
              tx_nxt = mk_msg(1'b0, remain_r - 8'h01);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r    <= wkt_pkg::WKT_IDLE;
      remain_r   <= 8'h00;
      o_tx_valid <= 1'b0;
      o_tx       <= '0;
    end else begin
      state_r    <= state_nxt;
      remain_r   <= remain_nxt;
      o_tx_valid <= tx_vld_nxt;
      o_tx       <= tx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt.

  always_comb begin
    cmp_nxt  = cmp_r;
    plen_nxt = plen_r;
    en_nxt   = en_r;
    clr      = '0;
    if (hit(i_bus, wkt_pkg::ADDR_CMP)) begin
      cmp_nxt = i_bus.wdata[15:0];
    end
    if (hit(i_bus, wkt_pkg::ADDR_PLEN)) begin
      plen_nxt = i_bus.wdata[15:0];
    end
    if (hit(i_bus, wkt_pkg::ADDR_ENABLE)) begin
      en_nxt = i_bus.wdata[wkt_pkg::STS_W-1:0];
    end
    if (hit(i_bus, wkt_pkg::ADDR_CLEAR)) begin
      clr = i_bus.wdata[wkt_pkg::STS_W-1:0];
    end
    evt = '0;
    evt[wkt_pkg::STS_TICK] = tick;
    evt[wkt_pkg::STS_WAKE] = wake_go;
    evt[wkt_pkg::STS_LOAD] = i_rx_valid;
    // A new event beats a clear in the same cycle.
    status_nxt = (status_r & ~clr) | evt;
    irq_nxt    = |(status_nxt & en_nxt);
    rdata_nxt  = 32'h0000_0000;
    if (i_bus.rd) begin
      case (i_bus.addr)
        wkt_pkg::ADDR_CMP:    rdata_nxt = {16'h0000, cmp_r};
        wkt_pkg::ADDR_REMAIN: rdata_nxt = {23'h000000,
                                           state_r == wkt_pkg::WKT_COUNT,
                                           remain_r};
        wkt_pkg::ADDR_STATUS: rdata_nxt = {29'h00000000, status_r};
        wkt_pkg::ADDR_ENABLE: rdata_nxt = {29'h00000000, en_r};
        wkt_pkg::ADDR_PLEN:   rdata_nxt = {16'h0000, plen_r};
        default:              rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_r    <= wkt_pkg::CMP_RESET;
      plen_r   <= wkt_pkg::PLEN_RESET;
      en_r     <= wkt_pkg::EN_RESET;
      status_r <= wkt_pkg::STS_RESET;
      o_rdata  <= 32'h0000_0000;
      o_irq    <= 1'b0;
    end else begin
      cmp_r    <= cmp_nxt;
      plen_r   <= plen_nxt;
      en_r     <= en_nxt;
      status_r <= status_nxt;
      o_rdata  <= rdata_nxt;
      o_irq    <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_load_remain: assert property (
    i_rx_valid |=> remain_r == $past(i_rx_data))
    else $error("new wake time not loaded");

  a_load_start: assert property (
    i_rx_valid && i_rx_data != 8'h00 |=> state_r == wkt_pkg::WKT_COUNT)
    else $error("countdown did not start on byte");

  a_zero_idle: assert property (
    i_rx_valid && i_rx_data == 8'h00 |=> state_r == wkt_pkg::WKT_IDLE
      ##1 !o_tx_valid)
    else $error("zero wake time started a countdown");

  a_report_step: assert property (
    !i_rx_valid && tick && state_r == wkt_pkg::WKT_COUNT
      && remain_r > 8'h01
      |=> o_tx_valid && !o_tx.is_wake
        && o_tx.secs == $past(remain_r) - 8'h01)
    else $error("remaining seconds report wrong");

  a_wake_notify: assert property (
    !i_rx_valid && tick && state_r == wkt_pkg::WKT_COUNT
      && remain_r == 8'h01
      |=> o_tx_valid && o_tx.is_wake && o_wake
        && state_r == wkt_pkg::WKT_IDLE)
    else $error("wake message or wake line missing at zero");

  a_wake_rise: assert property (
    !i_rx_valid && tick && state_r == wkt_pkg::WKT_COUNT
      && remain_r == 8'h01 && !o_wake |=> $rose(o_wake))
    else $error("wake line did not rise at zero");

  a_tx_cause: assert property (
    o_tx_valid |-> $past(tick) && $past(state_r) == wkt_pkg::WKT_COUNT
      && !$past(i_rx_valid))
    else $error("link message without a counting tick");

  a_irq_wake: assert property (
    $rose(status_r[wkt_pkg::STS_WAKE]) && en_r[wkt_pkg::STS_WAKE]
      |-> o_irq)
    else $error("enabled wake event did not raise interrupt");

  a_clear_loses: assert property (
    tick && hit(i_bus, wkt_pkg::ADDR_CLEAR)
      && i_bus.wdata[wkt_pkg::STS_TICK] |=> status_r[wkt_pkg::STS_TICK])
    else $error("tick event lost to a clear");

  a_rdata_idle: assert property (
    !i_bus.rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  a_cmp_write: assert property (
    hit(i_bus, wkt_pkg::ADDR_CMP)
      |=> cmp_r == $past(i_bus.wdata[15:0]))
    else $error("compare value write not taken");

  a_idle_quiet: assert property (
    state_r == wkt_pkg::WKT_IDLE |=> !o_tx_valid)
    else $error("link message while no countdown runs");

  a_remain_step: assert property (
    !i_rx_valid && tick && state_r == wkt_pkg::WKT_COUNT
      |=> remain_r == $past(remain_r) - 8'h01)
    else $error("remaining seconds not decremented on tick");

  a_wake_sticky: assert property (
    status_r[wkt_pkg::STS_WAKE]
      && !(hit(i_bus, wkt_pkg::ADDR_CLEAR)
        && i_bus.wdata[wkt_pkg::STS_WAKE])
      |=> status_r[wkt_pkg::STS_WAKE])
    else $error("wake status bit dropped without a clear");

endmodule
